//--- core/mhp_host_port.sv
// multiplexed host port: 16-bit host bus to 32-bit internal memory,
// with control and address registers, 8-word read and write fifos.
// assumes a simple req/ack memory port and an apb master for the cpu.
//
// Overview of operation
// [RULE1] access-control levels are latched at internal strobe fall for the transfer
// [RULE2] four access-control states decode to four register access types
// [RULE3] code 01 reaches the address register: write loads, read returns it
// [RULE4] code 10 is data access that steps the relevant address afterwards
// [RULE5] code 00 is control register, code 11 data without address step
// [RULE6] port responds only while select is low; select may stay low
// [RULE7] direction high means host reads; latched at internal strobe fall
// [RULE8] host marks first halfword with identifier low, second high
// [RULE9] address strobe pin is unused and held high by the system
// [RULE10] cpu writing 1 to host-interrupt bit sets it, raising host interrupt
// [RULE11] host writing 1 to host-interrupt bit clears it as acknowledge
// [RULE12] interrupt pin is active low, inverse of host-interrupt bit
// [RULE13] data write captures host bus at the rising strobe edge
// [RULE14] host bus is driven on reads only while strobe is active
// [RULE15] ready low lets host finish, high stalls it
// [RULE16] host-written addresses are kept in 32-bit address registers
// [RULE17] host cycle is two 16-bit transfers in dual-halfword mode
// [RULE18] 16-bit host bus; halfwords assemble and split 32-bit words
// [RULE19] separate read and write address registers, optionally shared
// [RULE20] autoincrement bursts use separate 8-word read and write fifos
// [RULE21] without autoincrement only one fifo location is used; plain data writes still queue up to 8 words in the write fifo
// [RULE22] data register holds write data until stored, read data until returned
// [RULE23] control register is reachable by both host and cpu
// [RULE24] cpu can interrupt host, clear host interrupt and watch the port; here a cpu write clears only the host-to-cpu bit, never the host-interrupt bit
// [RULE25] host strobe, select and control inputs are synchronised before use; ready and bus enable use the raw pins
// [RULE26] select high forces ready low regardless of internal progress
// [RULE27] ready stays high from data read strobe fall until word is valid
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module mhp_host_port
   import mhp_pkg::*;
#(
   parameter int DEPTH = MHP_FIFO_DEPTH
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        clk_en_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             cpu_interrupt_o,
   // host pins
   input  wire logic [1:0]  access_control_in_i,
   input  wire logic        port_select_n_i,
   input  wire logic        read_not_write_i,
   input  wire logic        halfword_identifier_i,
   input  wire logic        data_strobe_one_i,
   input  wire logic        data_strobe_two_i,
   input  wire logic [15:0] host_data_bus_i,
   output logic      [15:0] host_data_bus_o,
   output logic             host_data_bus_oe_o,
   output logic             ready_n_o,
   output logic             host_interrupt_n_o,
   // internal memory port
   output logic             mem_req_o,
   output logic             mem_we_o,
   output logic      [31:0] mem_addr_o,
   output logic      [31:0] mem_wdata_o,
   input  wire logic        mem_ack_i,
   input  wire logic [31:0] mem_rdata_i
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   typedef struct packed {
      logic [MHP_SYNC_W-1:0]         sync1;
      logic [MHP_SYNC_W-1:0]         sync2;
      logic                          strb_d;
      logic [1:0]                    acc;
      logic                          rnw;
      logic                          hwid;
      logic                          seen;
      logic                          pend;
      logic [15:0]                   lo_hold;
      logic [15:0]                   dout;
      logic                          host_int;
      logic                          cpu_int;
      logic                          hw_order;
      logic                          dual;
      logic                          asel;
      logic [31:0]                   write_addr;
      logic [31:0]                   read_addr;
      logic [31:0]                   fetch_addr;
      logic [AW:0]                   fetch_left;
      logic [DEPTH-1:0][31:0]        rfifo;
      logic [AW-1:0]                 rhead;
      logic [AW:0]                   rcount;
      logic [DEPTH-1:0][31:0]        wfifo;
      logic [DEPTH-1:0][31:0]        wfaddr;
      logic [AW-1:0]                 whead;
      logic [AW:0]                   wcount;
   } mhp_state_t;

   mhp_state_t s_reg;
   mhp_state_t s_next;

   logic        strb_raw;
   logic        strb;
   logic        fall;
   logic        rise;
   logic [15:0] hdata;
   logic [31:0] rd_head;
   logic [31:0] addr_view;
   logic [15:0] ctl_half;
   logic        apb_wr;
   logic        cpu_set;
   logic        cpu_clr;
   logic        host_set;
   logic        host_clr;
   logic        wr_take;

   // picks the halfword that goes out in the first or second transfer
   function automatic logic [15:0] mhp_half(input logic [31:0] w, input logic second,
                                           input logic lo_first);
      mhp_half = (second == lo_first) ? w[31:16] : w[15:0]; // RULE18
   endfunction : mhp_half

   ////////////////////////////////////////////////////////////////////////////
   // strobe combining and synchronised views
   assign strb_raw = ~port_select_n_i & (data_strobe_one_i ^ data_strobe_two_i);
   assign strb = ~s_reg.sync2[22] & (s_reg.sync2[21] ^ s_reg.sync2[20]); // RULE6
   assign fall = strb & ~s_reg.strb_d;
   assign rise = ~strb & s_reg.strb_d;
   assign hdata = s_reg.sync2[15:0];
   assign rd_head = s_reg.rfifo[s_reg.rhead];
   assign addr_view = (s_reg.dual & ~s_reg.asel) ? s_reg.write_addr : s_reg.read_addr;
   assign ctl_half = {11'h000, s_reg.dual, s_reg.asel, s_reg.host_int, s_reg.cpu_int,
                      s_reg.hw_order};

   // interrupt set and clear terms
   assign apb_wr = psel_i & penable_i & pwrite_i & clk_en_i;
   assign cpu_set = apb_wr & (paddr_i == MHP_OFS_CTRL) & pwdata_i[MHP_CTL_HOSTINT]; // RULE10
   assign cpu_clr = apb_wr & (paddr_i == MHP_OFS_CTRL) & pwdata_i[MHP_CTL_CPUINT]; // RULE24
   assign wr_take = rise & ~s_reg.rnw & ~s_reg.hwid & (s_reg.acc == MHP_ACC_CTRL);
   assign host_set = wr_take & hdata[MHP_CTL_CPUINT]; // RULE23
   assign host_clr = wr_take & hdata[MHP_CTL_HOSTINT]; // RULE11

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      logic [31:0]   word;
      logic [AW-1:0] idx;
      logic          auto;
      word = 32'h0000_0000;
      idx = '0;
      auto = 1'b0;
      s_next = s_reg;
      // two-flop synchroniser for all host inputs
      s_next.sync1 = {port_select_n_i, data_strobe_one_i, data_strobe_two_i, // RULE25
                      read_not_write_i, halfword_identifier_i, access_control_in_i,
                      host_data_bus_i};
      s_next.sync2 = s_reg.sync1;
      s_next.strb_d = strb;

      // memory port completion: writes drain first, then read fetches
      if (mem_ack_i && s_reg.wcount != '0) begin
         s_next.whead = s_reg.whead + 1'b1;
         s_next.wcount = s_reg.wcount - 1'b1; // RULE22
      end else if (mem_ack_i && s_reg.fetch_left != '0) begin
         idx = s_reg.rhead + AW'(s_reg.rcount);
         s_next.rfifo[idx] = mem_rdata_i;
         s_next.rcount = s_reg.rcount + 1'b1;
         s_next.fetch_left = s_reg.fetch_left - 1'b1;
         s_next.fetch_addr = s_reg.fetch_addr + MHP_ADDR_STEP;
      end

      // strobe fall: latch control and prepare the answer
      if (fall) begin
         s_next.acc = s_reg.sync2[17:16]; // RULE1
         s_next.rnw = s_reg.sync2[19]; // RULE7
         s_next.hwid = s_reg.sync2[18];
         s_next.seen = 1'b1;
         if (s_reg.sync2[19]) begin
            case (s_reg.sync2[17:16]) // RULE2
               MHP_ACC_CTRL: s_next.dout = mhp_half({16'h0000, ctl_half}, // RULE5
                                                    s_reg.sync2[18], s_reg.hw_order);
               MHP_ACC_ADDR: s_next.dout = mhp_half(addr_view, s_reg.sync2[18],
                                                    s_reg.hw_order); // RULE3
               default: begin
                  if (s_reg.rcount != '0) begin
                     s_next.dout = mhp_half(rd_head, s_reg.sync2[18], s_reg.hw_order);
                  end else begin
                     s_next.pend = 1'b1; // RULE27
                     if (s_reg.fetch_left == '0) begin
                        s_next.fetch_addr = s_reg.read_addr;
                        // single location unless bursting
                        s_next.fetch_left = (s_reg.sync2[17:16] == MHP_ACC_AUTO) ?
                                            FULL : (AW + 1)'(1); // RULE20 RULE21
                     end
                  end
               end
            endcase
         end else if (s_reg.sync2[17] && s_reg.sync2[18] && s_reg.wcount == FULL) begin
            s_next.pend = 1'b1; // RULE15
         end
      end

      // release a stalled transfer once data or room is there
      if (s_reg.pend && s_reg.rnw && s_reg.rcount != '0) begin
         s_next.dout = mhp_half(rd_head, s_reg.hwid, s_reg.hw_order);
         s_next.pend = 1'b0;
      end else if (s_reg.pend && !s_reg.rnw && s_next.wcount != FULL) begin
         s_next.pend = 1'b0;
      end

      // strobe rise: finish the transfer
      if (rise) begin
         s_next.seen = 1'b0;
         auto = (s_reg.acc == MHP_ACC_AUTO);
         if (!s_reg.rnw && !s_reg.hwid) begin
            s_next.lo_hold = hdata; // RULE13
            if (s_reg.acc == MHP_ACC_CTRL) begin
               s_next.hw_order = hdata[MHP_CTL_HWORD];
               s_next.asel = hdata[MHP_CTL_ASEL];
               s_next.dual = hdata[MHP_CTL_DUAL];
            end
         end else if (!s_reg.rnw) begin
            word = s_reg.hw_order ? {hdata, s_reg.lo_hold} : {s_reg.lo_hold, hdata}; // RULE17
            if (s_reg.acc == MHP_ACC_ADDR) begin
               if (!s_reg.dual || !s_reg.asel) begin
                  s_next.write_addr = word; // RULE16 RULE19
               end
               if (!s_reg.dual || s_reg.asel) begin
                  s_next.read_addr = word;
                  s_next.rcount = '0;
                  s_next.fetch_left = '0;
               end
            end else if (s_reg.acc[1] && s_next.wcount != FULL) begin
               // tail from the updated head, so a drain in this cycle keeps the entry
               idx = s_next.whead + AW'(s_next.wcount);
               s_next.wfifo[idx] = word;
               s_next.wfaddr[idx] = s_reg.write_addr;
               s_next.wcount = s_next.wcount + 1'b1;
               if (auto) begin
                  s_next.write_addr = s_reg.write_addr + MHP_ADDR_STEP; // RULE4
                  if (!s_reg.dual) begin
                     s_next.read_addr = s_reg.write_addr + MHP_ADDR_STEP;
                  end
               end
            end
         end else if (s_reg.acc[1] && s_reg.hwid && s_reg.rcount != '0) begin
            // word consumed: pop, step the read address on autoincrement
            s_next.rhead = s_reg.rhead + 1'b1;
            s_next.rcount = s_next.rcount - 1'b1;
            if (auto) begin
               s_next.read_addr = s_reg.read_addr + MHP_ADDR_STEP; // RULE4
               if (!s_reg.dual) begin
                  s_next.write_addr = s_reg.read_addr + MHP_ADDR_STEP;
               end
            end else begin
               s_next.rcount = '0; // RULE21
            end
         end
      end

      // cpu address writes
      if (apb_wr && paddr_i == MHP_OFS_WADDR) begin
         s_next.write_addr = pwdata_i;
      end
      if (apb_wr && paddr_i == MHP_OFS_RADDR) begin
         s_next.read_addr = pwdata_i;
      end

      // interrupt bits: a set in the same cycle wins over the clear
      s_next.host_int = (s_reg.host_int & ~host_clr) | cpu_set; // RULE10 RULE11
      s_next.cpu_int = (s_reg.cpu_int & ~cpu_clr) | host_set; // RULE24
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register, frozen while the clock enable is low
   always_ff @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         s_reg <= '0;
         s_reg.sync1 <= {3'h7, {(MHP_SYNC_W - 3){1'b0}}};
         s_reg.sync2 <= {3'h7, {(MHP_SYNC_W - 3){1'b0}}};
         {s_reg.dual, s_reg.asel, s_reg.host_int, s_reg.cpu_int, s_reg.hw_order} <=
            MHP_CTL_RST;
         s_reg.write_addr <= MHP_ADDR_RST;
         s_reg.read_addr <= MHP_ADDR_RST;
      end else if (clk_en_i) begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // host pin outputs
   assign host_data_bus_o = s_reg.dout;
   assign host_data_bus_oe_o = strb_raw & read_not_write_i; // RULE14
   assign ready_n_o = ~port_select_n_i & (s_reg.pend | (strb_raw & ~s_reg.seen)); // RULE26
   assign host_interrupt_n_o = ~s_reg.host_int; // RULE12
   assign cpu_interrupt_o = s_reg.cpu_int;

   // memory port: writes drain before reads are fetched
   assign mem_we_o = (s_reg.wcount != '0);
   assign mem_req_o = mem_we_o | (s_reg.fetch_left != '0);
   assign mem_addr_o = mem_we_o ? s_reg.wfaddr[s_reg.whead] : s_reg.fetch_addr;
   assign mem_wdata_o = s_reg.wfifo[s_reg.whead];

   // apb answer: one access cycle, error on unmapped offsets
   always_comb begin
      prdata_o = 32'h0000_0000;
      pslverr_o = 1'b0;
      case (paddr_i)
         MHP_OFS_CTRL: prdata_o = {16'h0000, ctl_half};
         MHP_OFS_WADDR: prdata_o = s_reg.write_addr;
         MHP_OFS_RADDR: prdata_o = s_reg.read_addr;
         MHP_OFS_STAT: prdata_o = {16'h0000, 3'h0, s_reg.pend, 4'(s_reg.wcount),
                                   4'(s_reg.rcount), 4'(s_reg.fetch_left)};
         default: pslverr_o = psel_i & penable_i;
      endcase
   end
   assign pready_o = clk_en_i;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   deselect_ready_a: assert property (port_select_n_i |-> !ready_n_o) // RULE26
      else $error("ready not low while deselected");
   int_pin_a: assert property (host_interrupt_n_o == !s_reg.host_int) // RULE12
      else $error("interrupt pin not inverse of bit");
   read_drive_a: assert property (host_data_bus_oe_o |-> strb_raw && read_not_write_i) // RULE14
      else $error("bus driven outside read strobe");
   cpu_raise_a: assert property (cpu_set |=> s_reg.host_int && !host_interrupt_n_o) // RULE10
      else $error("cpu set did not raise host interrupt");
   host_ack_a: assert property (clk_en_i && host_clr && !cpu_set |=> !s_reg.host_int) // RULE11
      else $error("host acknowledge did not clear bit");
   fifo_bound_a: assert property (s_reg.wcount <= FULL && s_reg.rcount <= FULL) // RULE20
      else $error("fifo count above depth");
   auto_step_a: assert property (clk_en_i && rise && s_reg.rnw && s_reg.hwid
      && s_reg.acc == MHP_ACC_AUTO && s_reg.rcount != '0
      |=> s_reg.read_addr == $past(s_reg.read_addr) + MHP_ADDR_STEP) // RULE4
      else $error("read address not stepped");
   plain_single_a: assert property (clk_en_i && fall && s_reg.sync2[19]
      && s_reg.sync2[17:16] == MHP_ACC_DATA && s_reg.rcount == '0
      && s_reg.fetch_left == '0 |=> s_reg.fetch_left == 1) // RULE21
      else $error("plain read fetched more than one word");
   read_stall_a: assert property (clk_en_i && fall && s_reg.sync2[19] && s_reg.sync2[17]
      && s_reg.rcount == '0 |=> s_reg.pend && (port_select_n_i || ready_n_o)) // RULE27
      else $error("ready not held during read fetch");

   burst_read_c: cover property (rise && s_reg.rnw && s_reg.acc == MHP_ACC_AUTO);
   burst_write_c: cover property (s_reg.wcount == FULL);
   addr_load_c: cover property (rise && !s_reg.rnw && s_reg.acc == MHP_ACC_ADDR);
   int_ack_c: cover property (host_clr);

endmodule : mhp_host_port

//--- core/mhp_pkg.sv
// constants for the multiplexed host port: access codes, control bits,
// apb register offsets and reset values.
// assumes nothing beyond a systemverilog compiler.
package mhp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // host access-control codes
   localparam logic [1:0] MHP_ACC_CTRL = 2'h0;  // control register
   localparam logic [1:0] MHP_ACC_ADDR = 2'h1;  // address register
   localparam logic [1:0] MHP_ACC_AUTO = 2'h2;  // data with autoincrement
   localparam logic [1:0] MHP_ACC_DATA = 2'h3;  // data, address unchanged

   ////////////////////////////////////////////////////////////////////////////
   // control register bit positions (host and cpu view)
   localparam int MHP_CTL_HWORD = 0;  // 1: first halfword is the low half
   localparam int MHP_CTL_CPUINT = 1;  // host to cpu interrupt
   localparam int MHP_CTL_HOSTINT = 2;  // cpu to host interrupt
   localparam int MHP_CTL_ASEL = 3;  // dual mode: 1 selects read address
   localparam int MHP_CTL_DUAL = 4;  // 1: two independent address registers

   ////////////////////////////////////////////////////////////////////////////
   // apb register byte offsets
   localparam logic [11:0] MHP_OFS_CTRL = 12'h000;
   localparam logic [11:0] MHP_OFS_WADDR = 12'h004;
   localparam logic [11:0] MHP_OFS_RADDR = 12'h008;
   localparam logic [11:0] MHP_OFS_STAT = 12'h00c;

   ////////////////////////////////////////////////////////////////////////////
   // sizes, steps and reset values
   localparam int MHP_HALF_W = 16;
   localparam int MHP_WORD_W = 32;
   localparam int MHP_FIFO_DEPTH = 8;
   localparam logic [31:0] MHP_ADDR_STEP = 32'h0000_0004;
   localparam logic [31:0] MHP_ADDR_RST = 32'h0000_0000;
   localparam logic [4:0] MHP_CTL_RST = 5'h00;
   // synchroniser vector: cs_n, ds1, ds2, rnw, hwid, acc[1:0], data[15:0]
   localparam int MHP_SYNC_W = 23;

endpackage : mhp_pkg

//--- testbench/mhp_partner.sv
// host processor and internal memory models for the host port bench.
// assumes one clock; the bench calls the host task hierarchically.
`timescale 1ns/10ps

module mhp_host_model (
   input  wire logic        core_clk_i,
   input  wire logic [15:0] dev_data_i,
   input  wire logic        dev_oe_i,
   input  wire logic        ready_n_i,
   output logic      [1:0]  acc_o,
   output logic             sel_n_o,
   output logic             rnw_o,
   output logic             hwid_o,
   output logic             ds1_o,
   output logic      [15:0] bus_o
);
   logic [15:0] drv;
   logic        drv_en;
   logic [15:0] last;

   // wire level: device, then host, else a pattern that keeps changing
   assign bus_o = dev_oe_i ? dev_data_i : (drv_en ? drv : ~last);
   always @(posedge core_clk_i) last <= bus_o;

   // idle levels; the host's address strobe is tied high off-chip
   initial begin
      {acc_o, rnw_o, hwid_o, drv, drv_en, last} = '0;
      sel_n_o = 1'b1;
      ds1_o = 1'b1;
   end

   // one halfword transfer, request held until ready is seen low
   task automatic xfer(input logic sel_n, input logic [1:0] acc, input logic rnw,
                       input logic hw, input logic [15:0] din, output logic [15:0] dout);
      @(posedge core_clk_i);
      sel_n_o <= sel_n;
      acc_o <= acc;
      rnw_o <= rnw;
      hwid_o <= hw;
      drv <= din;
      drv_en <= ~rnw;
      ds1_o <= 1'b0;
      do begin
         @(posedge core_clk_i);
      end while (ready_n_i !== 1'b0);
      dout = bus_o;
      ds1_o <= 1'b1;
      // data held and strobe high past the device's rise detection
      repeat (5) @(posedge core_clk_i);
      drv_en <= 1'b0;
      sel_n_o <= 1'b1;
   endtask : xfer
endmodule : mhp_host_model

////////////////////////////////////////////////////////////////////////////////
module mhp_mem_model (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        req_i,
   input  wire logic        we_i,
   input  wire logic [31:0] addr_i,
   input  wire logic [31:0] wdata_i,
   output logic             ack_o,
   output logic      [31:0] rdata_o
);
   logic [31:0] mem [0:63];
   int          lat;
   int          cnt;

   // read data only valid with ack
   assign rdata_o = ack_o ? mem[addr_i[7:2]] : ~mem[addr_i[7:2]];

   initial begin
      lat = 0;
      foreach (mem[i]) mem[i] = 32'h0000_0000;
   end

   // one ack pulse after lat idle cycles of a held request
   always @(posedge core_clk_i) begin
      if (!rst_n_i || ack_o || !req_i) begin
         if (ack_o && we_i) mem[addr_i[7:2]] <= wdata_i;
         ack_o <= 1'b0;
         cnt <= 0;
      end else if (cnt >= lat) begin
         ack_o <= 1'b1;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : mhp_mem_model

//--- testbench/multiplexed_host_port_bench.sv
// self-checking bench for the multiplexed host port.
// assumes the host and memory models of mhp_partner.sv.
`timescale 1ns/10ps

module multiplexed_host_port_bench
   import mhp_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        clk_en = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, last_err, cpu_int, rdy_n, host_interrupt_n, dev_oe, ds1;
   logic        sel_n, rnw, hwid, mem_req, mem_we, mem_ack;
   logic [1:0]  acc;
   logic [15:0] bus, dev_dout;
   logic [31:0] mem_addr, mem_wdata, mem_rdata, d;
   int          fail_count = 0;
   int          n_checks = 0;
   int          cyc = 0;

   always #5 core_clk = ~core_clk;

   mhp_host_port u_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .clk_en_i(clk_en),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .cpu_interrupt_o(cpu_int), .access_control_in_i(acc), .port_select_n_i(sel_n),
      .read_not_write_i(rnw), .halfword_identifier_i(hwid), .data_strobe_one_i(ds1),
      .data_strobe_two_i(1'b1), .host_data_bus_i(bus), .host_data_bus_o(dev_dout),
      .host_data_bus_oe_o(dev_oe), .ready_n_o(rdy_n), .host_interrupt_n_o(host_interrupt_n),
      .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
      .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata));
   mhp_host_model u_host (.core_clk_i(core_clk), .dev_data_i(dev_dout), .dev_oe_i(dev_oe),
      .ready_n_i(rdy_n), .acc_o(acc), .sel_n_o(sel_n), .rnw_o(rnw), .hwid_o(hwid),
      .ds1_o(ds1), .bus_o(bus));
   mhp_mem_model u_mem (.core_clk_i(core_clk), .rst_n_i(rst_n), .req_i(mem_req),
      .we_i(mem_we), .addr_i(mem_addr), .wdata_i(mem_wdata), .ack_o(mem_ack),
      .rdata_o(mem_rdata));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // apb transfer: setup, access held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // return once the write has settled in the registers
      @(negedge core_clk);
   endtask : apb

   // host cycle: halfword 0 carries wd[15:0], halfword 1 wd[31:16]
   task automatic hword(input logic sel_n, input logic [1:0] a, input logic r,
                        input logic [31:0] wd, output logic [31:0] rd);
      logic [15:0] lo, hi;
      u_host.xfer(sel_n, a, r, 1'b0, wd[15:0], lo);
      u_host.xfer(sel_n, a, r, 1'b1, wd[31:16], hi);
      rd = {hi, lo};
   endtask : hword

   // wait until no write is pending
   task automatic drain();
      logic [31:0] s;
      do begin
         apb(1'b0, MHP_OFS_STAT, 32'h0, s);
      end while (s[12:8] !== 5'h00);
   endtask : drain

   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out

   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      chk(host_interrupt_n, 1'b1);
      chk(rdy_n, 1'b0);
      apb(1'b0, MHP_OFS_CTRL, 32'h0, d);
      chk(d, 32'h0);
      apb(1'b0, 12'h010, 32'h0, d);
      chk(last_err, 1'b1);
      chk(d, 32'h0);
      // clock enable low holds the apb answer off
      @(posedge core_clk);
      clk_en <= 1'b0;
      @(negedge core_clk);
      chk(pready, 1'b0);
      @(posedge core_clk);
      clk_en <= 1'b1;
      $display("test reset done");
      // control register from both sides, interrupts both ways
      hword(1'b0, MHP_ACC_CTRL, 1'b0, 32'h0001, d);
      apb(1'b0, MHP_OFS_CTRL, 32'h0, d);
      chk(d, 32'h1);
      hword(1'b0, MHP_ACC_CTRL, 1'b0, 32'h0003, d);
      chk(cpu_int, 1'b1);
      apb(1'b1, MHP_OFS_CTRL, 32'h2, d);
      chk(cpu_int, 1'b0);
      apb(1'b1, MHP_OFS_CTRL, 32'h4, d);
      chk(host_interrupt_n, 1'b0);
      hword(1'b0, MHP_ACC_CTRL, 1'b0, 32'h0005, d);
      chk(host_interrupt_n, 1'b1);
      hword(1'b0, MHP_ACC_CTRL, 1'b1, 32'h0, d);
      chk(d, 32'h1);
      hword(1'b1, MHP_ACC_CTRL, 1'b0, 32'h0003, d);
      chk({cpu_int, rdy_n}, 2'b00);
      $display("test control done");
      // address load and autoincrement writes
      hword(1'b0, MHP_ACC_ADDR, 1'b0, 32'h10, d);
      apb(1'b0, MHP_OFS_WADDR, 32'h0, d);
      chk(d, 32'h10);
      apb(1'b0, MHP_OFS_RADDR, 32'h0, d);
      chk(d, 32'h10);
      u_mem.lat = 3;
      hword(1'b0, MHP_ACC_AUTO, 1'b0, 32'h1234_5678, d);
      hword(1'b0, MHP_ACC_AUTO, 1'b0, 32'h9abc_def0, d);
      drain();
      chk(u_mem.mem[4], 32'h1234_5678);
      chk(u_mem.mem[5], 32'h9abc_def0);
      apb(1'b0, MHP_OFS_WADDR, 32'h0, d);
      chk(d, 32'h18);
      $display("test write done");
      // plain data access keeps the address
      hword(1'b0, MHP_ACC_ADDR, 1'b0, 32'h20, d);
      hword(1'b0, MHP_ACC_DATA, 1'b0, 32'hcafe_0001, d);
      drain();
      chk(u_mem.mem[8], 32'hcafe_0001);
      apb(1'b0, MHP_OFS_WADDR, 32'h0, d);
      chk(d, 32'h20);
      hword(1'b0, MHP_ACC_ADDR, 1'b1, 32'h0, d);
      chk(d, 32'h20);
      hword(1'b0, MHP_ACC_DATA, 1'b1, 32'h0, d);
      chk(d, 32'hcafe_0001);
      apb(1'b0, MHP_OFS_RADDR, 32'h0, d);
      chk(d, 32'h20);
      $display("test plain done");
      // autoincrement reads from a slow memory
      u_mem.lat = 8;
      hword(1'b0, MHP_ACC_ADDR, 1'b0, 32'h10, d);
      hword(1'b0, MHP_ACC_AUTO, 1'b1, 32'h0, d);
      chk(d, 32'h1234_5678);
      hword(1'b0, MHP_ACC_AUTO, 1'b1, 32'h0, d);
      chk(d, 32'h9abc_def0);
      chk(dev_oe, 1'b0);
      apb(1'b0, MHP_OFS_RADDR, 32'h0, d);
      chk(d, 32'h18);
      $display("test read done");
      // two independent address registers, host selects the read one
      hword(1'b0, MHP_ACC_CTRL, 1'b0, 32'h0019, d);
      hword(1'b0, MHP_ACC_ADDR, 1'b0, 32'h30, d);
      apb(1'b0, MHP_OFS_WADDR, 32'h0, d);
      chk(d, 32'h18);
      hword(1'b0, MHP_ACC_ADDR, 1'b1, 32'h0, d);
      chk(d, 32'h30);
      $display("test dual done");
      close_out();
   end
endmodule : multiplexed_host_port_bench
